// *** design/pt_pkg.sv ***
/*
  Package for the 8-bit period timer: register map, field layout,
  reset values, prescale encodings and carrier structs.
  Assumes a 32-bit APB register bus and a single 50 MHz clock.
*/
`default_nettype none
package pt_pkg;

  // ==========================================================
  // Register indices and byte addresses
  // ==========================================================
  localparam logic [7:0] PT_IDX_TICK_COUNT = 8'h11;
  localparam logic [7:0] PT_IDX_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] PT_IDX_PERIOD_LIMIT = 8'h92;
  localparam logic [7:0] PT_IDX_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] PT_IDX_IRQ_MASK = 8'hA1;
  localparam int PT_ADDR_W = 12;
  localparam logic [11:0] PT_ADDR_TICK_COUNT = {2'h0, PT_IDX_TICK_COUNT, 2'h0};
  localparam logic [11:0] PT_ADDR_TIMER_CONTROL = {2'h0, PT_IDX_TIMER_CONTROL, 2'h0};
  localparam logic [11:0] PT_ADDR_PERIOD_LIMIT = {2'h0, PT_IDX_PERIOD_LIMIT, 2'h0};
  localparam logic [11:0] PT_ADDR_IRQ_STATUS = {2'h0, PT_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] PT_ADDR_IRQ_MASK = {2'h0, PT_IDX_IRQ_MASK, 2'h0};

  // ==========================================================
  // Reset values and field positions
  // ==========================================================
  localparam logic [7:0] PT_RST_TICK_COUNT = 8'h00;
  localparam logic [6:0] PT_RST_TIMER_CONTROL = 7'h00;
  localparam logic [7:0] PT_RST_PERIOD_LIMIT = 8'hFF;
  localparam int PT_CTL_RUN_BIT = 2;
  localparam int PT_IRQ_MATCH_BIT = 1;
  localparam logic [1:0] PT_IRQ_RST = 2'h0;

  // Prescale select encodings
  localparam logic [1:0] PT_PS_DIV1 = 2'h0;
  localparam logic [1:0] PT_PS_DIV4 = 2'h1;
  localparam logic [3:0] PT_PS_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PT_PS_LAST_DIV16 = 4'hF;

  // Instruction clock divides the core clock by four
  localparam logic [1:0] PT_ICLK_LAST = 2'h3;

  // Control register layout, bit 7 unimplemented
  typedef struct packed {
    logic [3:0] postscale_select;
    logic run_bit;
    logic [1:0] prescale_select;
  } pt_ctrl_t;

  // Time base offered to PWM logic; serial logic gets only the match
  typedef struct packed {
    logic [7:0] count;
    logic match;
  } pt_tbase_t;

endpackage : pt_pkg
`default_nettype wire

// *** design/pt_prescaler.sv ***
/*
  Prescaler for the period timer: turns the instruction-clock enable
  into a count enable at 1:1, 1:4 or 1:16.
  Assumes inc_en_i is a one-cycle enable and clr_i clears the counter.
*/
`default_nettype none
module pt_prescaler
  import pt_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic inc_en_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);
  import pt_pkg::*;

  logic [3:0] pre_cnt;
  logic [3:0] last;

  // ==========================================================
  // Division ratio
  // ==========================================================
  // Select 00 passes through, 01 divides by 4, 1x by 16
  always_comb begin
    unique case (sel_i)
      PT_PS_DIV1: last = 4'h0;
      PT_PS_DIV4: last = PT_PS_LAST_DIV4;
      default: last = PT_PS_LAST_DIV16;
    endcase
  end

  // Counter cleared by reset and by count or control register writes
  always_ff @(posedge clk_i) begin
    if (!nrst_i || clr_i) begin
      pre_cnt <= 4'h0;
    end else if (inc_en_i) begin
      pre_cnt <= (pre_cnt >= last) ? 4'h0 : pre_cnt + 4'h1;
    end
  end

  assign tick_o = inc_en_i && (pre_cnt >= last);

endmodule : pt_prescaler
`default_nettype wire

// *** design/pt_timer.sv ***
/*
  8-bit period timer with prescaler, period match, 4-bit postscaler,
  sticky interrupt status and APB register access.
  Assumes an APB master on clk_i; the PWM and serial logic sample
  the time-base outputs on the same clock.
*/
`default_nettype none
module pt_timer
  import pt_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pt_pkg::PT_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic serial_match_o,
  output pt_pkg::pt_tbase_t pwm_tbase_o
);
  import pt_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  logic [7:0] tick_count;
  logic [7:0] period_limit;
  pt_ctrl_t timer_control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] iclk_div;
  logic [3:0] post_cnt;
  logic iclk_en;
  logic pre_tick;
  logic match_pulse;
  logic post_done;
  logic wr_acc;
  logic rd_acc;
  logic wr_count;
  logic wr_ctrl;
  logic scaler_clr;
  logic addr_ok;
  logic [31:0] next_rdata;

  // APB access phase, always answered at once
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign wr_count = wr_acc && (paddr_i == PT_ADDR_TICK_COUNT);
  assign wr_ctrl = wr_acc && (paddr_i == PT_ADDR_TIMER_CONTROL);
  assign scaler_clr = wr_count || wr_ctrl;

  // ==========================================================
  // Instruction clock and prescaler
  // ==========================================================
  // Core clock divided by four, gated by run bit
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !timer_control.run_bit) begin
      iclk_div <= 2'h0;
    end else begin
      iclk_div <= iclk_div + 2'h1;
    end
  end
  assign iclk_en = timer_control.run_bit && (iclk_div == PT_ICLK_LAST);

  // Prescaler module handles ratio select
  pt_prescaler u_pre (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clr_i(scaler_clr),
    .inc_en_i(iclk_en),
    .sel_i(timer_control.prescale_select),
    .tick_o(pre_tick)
  );

  // ==========================================================
  // Count and period match
  // ==========================================================
  assign match_pulse = pre_tick && !wr_count && (tick_count == period_limit);

  // Count register: software write wins over increment
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tick_count <= PT_RST_TICK_COUNT;
    end else if (wr_count) begin
      tick_count <= pwdata_i[7:0];
    end else if (pre_tick) begin
      tick_count <= (tick_count == period_limit) ? 8'h00 : tick_count + 8'h01;
    end
  end

  // Period register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      period_limit <= PT_RST_PERIOD_LIMIT;
    end else if (wr_acc && paddr_i == PT_ADDR_PERIOD_LIMIT) begin
      period_limit <= pwdata_i[7:0];
    end
  end

  // Control register; writing it leaves the count alone
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      timer_control <= PT_RST_TIMER_CONTROL;
    end else if (wr_ctrl) begin
      timer_control <= pwdata_i[6:0];
    end
  end

  // ==========================================================
  // Postscaler
  // ==========================================================
  assign post_done = match_pulse && (post_cnt >= timer_control.postscale_select);

  // Counts matches; ratio is select plus one
  always_ff @(posedge clk_i) begin
    if (!nrst_i || scaler_clr) begin
      post_cnt <= 4'h0;
    end else if (match_pulse) begin
      post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  // ==========================================================
  // Set wins over the clear-on-read; only bits already reported are cleared,
  // so an event landing on the setup edge is not lost
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_status <= PT_IRQ_RST;
    end else begin
      if (rd_acc && paddr_i == PT_ADDR_IRQ_STATUS) begin
        irq_status <= irq_status & ~prdata_o[1:0];
      end
      if (post_done) begin
        irq_status[PT_IRQ_MATCH_BIT] <= 1'b1;
      end
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_mask <= PT_IRQ_RST;
    end else if (wr_acc && paddr_i == PT_ADDR_IRQ_MASK) begin
      irq_mask <= pwdata_i[1:0];
    end
  end

  // Registered interrupt level, follows status one cycle later
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Time-base outputs
  // ==========================================================
  // Match pulse and count for serial and PWM logic
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      serial_match_o <= 1'b0;
      pwm_tbase_o <= '0;
    end else begin
      serial_match_o <= match_pulse;
      pwm_tbase_o.match <= match_pulse;
      pwm_tbase_o.count <= tick_count;
    end
  end

  // ==========================================================
  // APB read path
  // ==========================================================
  // Read mux; bit 7 of control and unused bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr_i)
      PT_ADDR_TICK_COUNT: next_rdata[7:0] = tick_count;
      PT_ADDR_TIMER_CONTROL: next_rdata[6:0] = timer_control;
      PT_ADDR_PERIOD_LIMIT: next_rdata[7:0] = period_limit;
      PT_ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
      PT_ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer in the first access cycle, pready one-cycle pulse
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_count_wrap;
    @(posedge clk_i) disable iff (!nrst_i)
    (pre_tick && !wr_count && tick_count == period_limit) |=> (tick_count == 8'h00);
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("count did not wrap");

  property p_stop;
    @(posedge clk_i) disable iff (!nrst_i)
    (!timer_control.run_bit && !wr_count) |=> $stable(tick_count);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_ctrl_keeps_count;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_ctrl && !pre_tick) |=> $stable(tick_count) && post_cnt == 4'h0;
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("control write hit count");

  property p_flag_set;
    @(posedge clk_i) disable iff (!nrst_i)
    post_done |=> irq_status[PT_IRQ_MATCH_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match flag not set");

  property p_ratio_one;
    @(posedge clk_i) disable iff (!nrst_i)
    match_pulse |-> (post_done == (post_cnt == timer_control.postscale_select));
  endproperty
  a_ratio_one: assert property (p_ratio_one) else $error("ratio one missed");

  property p_serial;
    @(posedge clk_i) disable iff (!nrst_i)
    match_pulse |=> serial_match_o && pwm_tbase_o.match;
  endproperty
  a_serial: assert property (p_serial) else $error("match not forwarded");

  property p_period_reset;
    @(posedge clk_i) !nrst_i |=> period_limit == PT_RST_PERIOD_LIMIT && tick_count == 8'h00;
  endproperty
  a_period_reset: assert property (p_period_reset) else $error("reset values wrong");

  property p_iclk;
    @(posedge clk_i) disable iff (!nrst_i)
    iclk_en |=> !iclk_en [*3];
  endproperty
  a_iclk: assert property (p_iclk) else $error("instruction clock too fast");

endmodule : pt_timer
`default_nettype wire

// *** bench/pt_far_model.sv ***
/*
  Far-side model of the PWM and serial logic that use the timer.
  Assumes the time-base outputs are sampled on clk_i.
*/
`default_nettype none
module pt_far_model
  import pt_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire pt_pkg::pt_tbase_t tbase_i,
  input wire logic serial_match_i,
  output var int pwm_hits_o,
  output var int ser_hits_o,
  output var logic [7:0] peak_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Event tally
  // ==========================================================
  // Counts both match views and the highest count seen
  always_ff @(posedge clk_i) begin
    if (!nrst_i || clr_i) begin
      pwm_hits_o <= 0;
      ser_hits_o <= 0;
      peak_o <= 8'h00;
    end else begin
      if (tbase_i.match) pwm_hits_o <= pwm_hits_o + 1;
      if (serial_match_i) ser_hits_o <= ser_hits_o + 1;
      if (tbase_i.count > peak_o) peak_o <= tbase_i.count;
    end
  end
endmodule : pt_far_model
`default_nettype wire

// *** bench/pt_timer_tb.sv ***
/*
  Testbench for the period timer: APB register access, prescale,
  postscale, wrap and interrupt checks.
  Assumes pt_timer answers each APB access without wait states.
*/
`default_nettype none
module pt_timer_tb;
  import pt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pslverr_o, pready_o, irq_o, ser_m, far_clr, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  pt_pkg::pt_tbase_t tbase;
  int bad_count, compares, pwm_hits, ser_hits, d;
  logic [7:0] peak;
  pt_timer dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .serial_match_o(ser_m),
    .pwm_tbase_o(tbase));
  pt_far_model far_u (.clk_i(clk_i), .nrst_i(nrst_i), .clr_i(far_clr), .tbase_i(tbase),
    .serial_match_i(ser_m), .pwm_hits_o(pwm_hits), .ser_hits_o(ser_hits), .peak_o(peak));
  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= dat;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask : rdc
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, far_clr} = 5'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rdc(PT_ADDR_TICK_COUNT, 32'h0);
    rdc(PT_ADDR_TIMER_CONTROL, 32'h0);
    rdc(PT_ADDR_PERIOD_LIMIT, 32'hFF);
    rdc(12'h300, 32'h0);
    check(32'(err), 32'h1);
    wr(PT_ADDR_TIMER_CONTROL, 32'hFF);
    rdc(PT_ADDR_TIMER_CONTROL, 32'h7F);
    wr(PT_ADDR_TIMER_CONTROL, 32'h0);
    wr(PT_ADDR_TICK_COUNT, 32'h5A);
    rdc(PT_ADDR_TICK_COUNT, 32'h5A);
    // Each select runs 3.5 increments, then stops; count must hold at 3
    for (int s = 0; s < 4; s++) begin
      d = (s == 0) ? 1 : (s == 1) ? 4 : 16;
      wr(PT_ADDR_TICK_COUNT, 32'h0);
      wr(PT_ADDR_TIMER_CONTROL, 32'(s) | 32'h4);
      repeat (14 * d - 3) @(posedge clk_i);
      wr(PT_ADDR_TIMER_CONTROL, 32'h0);
      repeat (40) @(posedge clk_i);
      rdc(PT_ADDR_TICK_COUNT, 32'h3);
    end
    // Period 2 gives a match every 12 clocks; flag after N+1 matches
    wr(PT_ADDR_PERIOD_LIMIT, 32'h2);
    wr(PT_ADDR_IRQ_MASK, 32'h2);
    wr(PT_ADDR_TICK_COUNT, 32'h0);
    far_clr <= 1'b1;
    @(posedge clk_i);
    far_clr <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      d = (k == 3) ? 15 : k;
      wr(PT_ADDR_TICK_COUNT, 32'h0);
      wr(PT_ADDR_TIMER_CONTROL, 32'(d << 3) | 32'h4);
      repeat (12 * (d + 1) - 7) @(posedge clk_i);
      rdc(PT_ADDR_IRQ_STATUS, 32'h0);
      repeat (6) @(posedge clk_i);
      check(32'(irq_o), 32'h1);
      rdc(PT_ADDR_IRQ_STATUS, 32'h2);
      @(posedge clk_i);
      check(32'(irq_o), 32'h0);
      wr(PT_ADDR_TIMER_CONTROL, 32'h0);
    end
    check(32'(peak), 32'h2);
    check(32'(pwm_hits), 32'(ser_hits));
    check(32'(ser_hits > 4), 32'h1);
    // Masked flag must not raise the interrupt
    wr(PT_ADDR_IRQ_MASK, 32'h0);
    wr(PT_ADDR_TIMER_CONTROL, 32'h4);
    repeat (30) @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    rdc(PT_ADDR_IRQ_STATUS, 32'h2);
    tally_and_finish();
  end
endmodule : pt_timer_tb
`default_nettype wire
